/* hw/bcf_pkg.sv */
// Constants, types and field layouts for the passthrough cell framer
// Contract
// [RULE1] Passthrough sends each word as 34 bits, type field on top.
// [RULE2] Passthrough shows received top two bits as the receive word type.
// [RULE3] Passthrough leaves overhead bits untouched in both directions.
// [RULE4] User logic builds words in the switch command word format.
// [RULE5] Cell mode is passthrough plus cell sync enable; fixed length cells.
// [RULE6] Flow ready low: shift transmit cell clock to meet switch cell clock.
// [RULE7] Flow ready low: receive boundary lags transmit boundary by set words.
// [RULE8] Flow ready high: recover cell clock from stream, derive shifted one.
// [RULE9] Flow ready high: no receive pipeline adjustment; recovered clock out.
// [RULE10] Type 00 is a command word; 01, 10, 11 are data words.
// [RULE11] Scramble data words only, and only with scramble enable high.
// [RULE12] Cell mode restarts the scrambler at every cell boundary.
// [RULE13] Check received idle word pattern; flag link error if wrong.
// [RULE14] User logic sends idle words now and then in cell mode.
// [RULE15] Idle in last cell slot goes out with overhead bits 11.
// [RULE16] User drops transmit word valid to force an idle slot.
// [RULE17] Cell mode: received idle word drops receive word valid.
// [RULE18] Idle in last slot without 11 pulses the cell sync error.
// [RULE19] Direct link: mode 01, clock multiplier transmit, receive align.
// [RULE20] Direct link needs loop timing select low.
// [RULE21] Direct mode: passthrough high, cell sync enable low.
// [RULE22] Switch card ends use mode 00 as word boundary master.
// [RULE23] Port card ends use mode 11, align both directions.
// [RULE24] Mode bit 1 aligns transmit, bit 0 aligns receive.
// [RULE25] A word counter per cell finds the last slot.
package bcf_pkg;
   // Word types carried in the overhead bits
   localparam logic [1:0] BCF_TYPE_CMD  = 2'h0;
   localparam logic [1:0] BCF_TYPE_MARK = 2'h3;
   // Idle word: opcode byte plus fixed check pattern
   localparam logic [7:0]  BCF_IDLE_OP  = 8'ha5;
   localparam logic [7:0]  BCF_DLY_OP   = 8'h5a;
   localparam logic [23:0] BCF_IDLE_PAT = 24'hc3_3c_96;
   localparam logic [31:0] BCF_IDLE_WORD = {BCF_IDLE_OP, BCF_IDLE_PAT};
   // Scrambler seed and feedback taps
   localparam logic [31:0] BCF_SEED = 32'hffff_ffff;
   localparam logic [31:0] BCF_TAPS = 32'h9000_0000;
   // Register byte offsets
   localparam logic [3:0] BCF_OFF_CTRL   = 4'h0;
   localparam logic [3:0] BCF_OFF_TIMING = 4'h4;
   localparam logic [3:0] BCF_OFF_STATUS = 4'h8;
   localparam logic [3:0] BCF_OFF_ERRCNT = 4'hc;
   // Bus responses
   localparam logic [1:0] BCF_RESP_OK  = 2'h0;
   localparam logic [1:0] BCF_RESP_ERR = 2'h2;
   // Mode bit patterns
   localparam logic [1:0] BCF_MODE_MASTER = 2'h0;
   localparam logic [1:0] BCF_MODE_DIRECT = 2'h1;
   // Control register, bit 6 first
   typedef struct packed {
      logic       loop_timing_select;
      logic [1:0] mode;
      logic       flow_ready_input;
      logic       scramble_enable;
      logic       cell_sync_enable;
      logic       raw_passthrough;
   } bcf_ctrl_type;
   localparam bcf_ctrl_type BCF_CTRL_RST = 7'h05;
   // Timing register, cell length in bits 7:0
   typedef struct packed {
      logic [7:0] rx_delay;
      logic [7:0] tx_shift;
      logic [7:0] cell_len;
   } bcf_timing_type;
   localparam bcf_timing_type BCF_TIMING_RST = 24'h00_00_10;
   // Status register, sticky flags are write one to clear
   typedef struct packed {
      logic config_err;
      logic cell_err;
      logic link_err;
   } bcf_status_type;
   // One 34-bit serial word
   typedef struct packed {
      logic [1:0]  ovh;
      logic [31:0] data;
   } bcf_ser_word_type;
endpackage : bcf_pkg

/* hw/bcf_framer.sv */
// Passthrough, cell and direct mode framer with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
module bcf_framer
   import bcf_pkg::*;
#(
   parameter int DLY_MAX = 16
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite slave
   input  wire logic [3:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [3:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // User transmit side
   input  wire logic [31:0]       tx_data,
   input  wire logic [1:0]        tx_word_type,
   input  wire logic              tx_word_valid,
   // User receive side
   output logic [31:0]            rx_data,
   output logic [1:0]             rx_word_type,
   output logic                   rx_word_valid,
   output logic                   cell_sync_error_pulse,
   output logic                   link_error_pulse,
   // Serial word path
   output bcf_ser_word_type       tx_ser_word,
   input  wire bcf_ser_word_type  rx_ser_word,
   // Cell clock from the switch, 160 ns period
   input  wire logic              cell_clk_in,
   output logic                   tx_cell_clock,
   output logic                   rx_cell_clock,
   // Static configuration to the analog section
   output logic                   self_route_enable,
   output logic                   tx_align_enable,
   output logic                   rx_align_enable,
   output logic                   word_boundary_master,
   output logic                   tx_clock_from_cmu
);
   localparam int DW = $clog2(DLY_MAX);

   bcf_ctrl_type   ctrl_reg;
   bcf_timing_type timing_reg;
   bcf_status_type status_reg;
   logic [31:0]    errcnt_reg;
   logic           cell_mode;
   logic           config_bad;

   // Cell mode needs both passthrough and cell sync enable
   // [RULE5] [RULE21] cell mode entry
   assign cell_mode = ctrl_reg.raw_passthrough & ctrl_reg.cell_sync_enable;

   // Bad setups: cell mode unscrambled, direct link on loop timing
   // [RULE20] loop timing check
   assign config_bad = (cell_mode & ~ctrl_reg.scramble_enable) |
      (ctrl_reg.mode == BCF_MODE_DIRECT & ctrl_reg.loop_timing_select);

   // Configuration outputs straight from control flops
   // [RULE24] [RULE23] alignment enables
   assign tx_align_enable      = ctrl_reg.mode[1];
   assign rx_align_enable      = ctrl_reg.mode[0];
   // [RULE22] mode 00 owns the word boundary
   assign word_boundary_master = ctrl_reg.mode == BCF_MODE_MASTER;
   // [RULE19] direct link transmits from the clock multiplier
   assign tx_clock_from_cmu    = ~ctrl_reg.loop_timing_select;
   // [RULE1] passthrough turns self-routing off
   assign self_route_enable    = ~ctrl_reg.raw_passthrough;

   // Scrambler advances 32 bit steps per word
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      logic [31:0] v;
      v = s;
      for (int i = 0; i < 32; i++) begin
         v = {v[30:0], ^(v & BCF_TAPS)};
      end
      return v;
   endfunction : lfsr_step

   // ---- Cell clock pin synchroniser and edge finder
   logic cclk_meta_reg, cclk_sync_reg, cclk_prev_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cclk_meta_reg <= 1'b0;
         cclk_sync_reg <= 1'b0;
         cclk_prev_reg <= 1'b0;
      end else begin
         cclk_meta_reg <= cell_clk_in;
         cclk_sync_reg <= cclk_meta_reg;
         cclk_prev_reg <= cclk_sync_reg;
      end
   end
   logic cclk_edge;
   assign cclk_edge = cclk_sync_reg & ~cclk_prev_reg;

   // ---- Received marker recovers the cell clock
   logic rx_is_mark, rec_bound_reg;
   assign rx_is_mark = rx_ser_word.ovh == BCF_TYPE_MARK &&
                       rx_ser_word.data == BCF_IDLE_WORD;
   // [RULE8] boundary follows the marked idle
   always_ff @(posedge aclk) begin
      if (!aresetn) rec_bound_reg <= 1'b0;
      else          rec_bound_reg <= cell_mode & rx_is_mark;
   end

   // ---- Transmit cell boundary, shifted from its source
   logic       bound_src, tx_bound;
   logic [7:0] shift_cnt_reg;
   logic       shift_run_reg;
   // [RULE6] switch cell clock when several share a card
   assign bound_src = ctrl_reg.flow_ready_input ? rec_bound_reg : cclk_edge;
   assign tx_bound  = cell_mode & ((bound_src && timing_reg.tx_shift == 8'h0)
                      | (shift_run_reg && shift_cnt_reg == 8'h1));
   // [RULE8] phase shift of transmit cell clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_cnt_reg <= 8'h0;
         shift_run_reg <= 1'b0;
      end else if (bound_src && timing_reg.tx_shift != 8'h0) begin
         shift_cnt_reg <= timing_reg.tx_shift;
         shift_run_reg <= 1'b1;
      end else if (shift_run_reg) begin
         shift_cnt_reg <= shift_cnt_reg - 8'h1;
         shift_run_reg <= shift_cnt_reg != 8'h1;
      end
   end

   // ---- Transmit word slot counter
   logic [7:0] tx_cnt_reg, tx_slot, last_slot;
   logic       tx_last;
   assign last_slot = timing_reg.cell_len - 8'h1;
   assign tx_slot   = tx_bound ? 8'h0 : tx_cnt_reg;
   assign tx_last   = tx_slot == last_slot;
   // [RULE25] slot count restarts on the boundary
   always_ff @(posedge aclk) begin
      if (!aresetn)     tx_cnt_reg <= 8'h0;
      else if (tx_last) tx_cnt_reg <= 8'h0;
      else              tx_cnt_reg <= tx_slot + 8'h1;
   end

   // ---- Transmit framing and scrambling
   logic        tx_reseed_reg, tx_seed, tx_is_cmd;
   logic [31:0] tx_lfsr_reg, tx_mask;
   // [RULE12] restart the sequence on each cell
   assign tx_seed   = (cell_mode & tx_bound) | tx_reseed_reg;
   assign tx_mask   = tx_seed ? BCF_SEED : tx_lfsr_reg;
   // [RULE10] type 00 marks a command word
   assign tx_is_cmd = ~tx_word_valid | tx_word_type == BCF_TYPE_CMD;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_lfsr_reg   <= BCF_SEED;
         tx_reseed_reg <= 1'b0;
      end else begin
         tx_lfsr_reg   <= lfsr_step(tx_mask);
         tx_reseed_reg <= tx_is_cmd;
      end
   end
   // Serial word out, idle when the user has nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_ser_word <= '{ovh: BCF_TYPE_CMD, data: BCF_IDLE_WORD};
      end else if (!tx_word_valid) begin
         // [RULE15] mark the cell with an 11 idle
         tx_ser_word.ovh  <= (cell_mode & tx_last) ? BCF_TYPE_MARK
                                                   : BCF_TYPE_CMD;
         tx_ser_word.data <= BCF_IDLE_WORD;
      end else begin
         // [RULE1] type field becomes the top two bits
         tx_ser_word.ovh  <= tx_word_type;
         // [RULE11] only data words are scrambled
         tx_ser_word.data <= (ctrl_reg.scramble_enable & ~tx_is_cmd)
                             ? tx_data ^ tx_mask : tx_data;
      end
   end
   assign tx_cell_clock = tx_bound;

   // ---- Receive cell boundary
   logic [DLY_MAX-1:0] bound_hist_reg;
   logic [DW-1:0]      dly_idx;
   logic               rx_bound;
   always_ff @(posedge aclk) begin
      if (!aresetn) bound_hist_reg <= '0;
      else bound_hist_reg <= {bound_hist_reg[DLY_MAX-2:0], tx_bound};
   end
   assign dly_idx = DW'(timing_reg.rx_delay - 8'h1);
   // [RULE7] receive boundary lags transmit by set words
   // [RULE9] no adjustment with flow ready high
   assign rx_bound = ctrl_reg.flow_ready_input ? rec_bound_reg :
                     (timing_reg.rx_delay == 8'h0) ? tx_bound :
                     bound_hist_reg[dly_idx];
   assign rx_cell_clock = rx_bound & cell_mode;

   logic [7:0] rx_cnt_reg, rx_slot;
   logic       rx_last;
   assign rx_slot = rx_bound ? 8'h0 : rx_cnt_reg;
   assign rx_last = rx_slot == last_slot;
   // [RULE25] receive slot counter
   always_ff @(posedge aclk) begin
      if (!aresetn)     rx_cnt_reg <= 8'h0;
      else if (rx_last) rx_cnt_reg <= 8'h0;
      else              rx_cnt_reg <= rx_slot + 8'h1;
   end

   // ---- Receive classification
   logic rx_cmd, rx_idle_op, rx_idle, rx_bad_pat, rx_sync_err, rx_dly_cmd;
   assign rx_cmd      = rx_ser_word.ovh == BCF_TYPE_CMD;
   assign rx_idle_op  = rx_cmd && rx_ser_word.data[31:24] == BCF_IDLE_OP;
   assign rx_idle     = rx_idle_op | rx_is_mark;
   assign rx_dly_cmd  = rx_cmd && rx_ser_word.data[31:24] == BCF_DLY_OP;
   // [RULE13] idle pattern check, data words unchecked
   assign rx_bad_pat  = rx_idle_op && rx_ser_word.data[23:0] != BCF_IDLE_PAT;
   // [RULE18] last slot idle without 11
   assign rx_sync_err = cell_mode & rx_last & rx_idle_op;

   // ---- Receive descrambling and outputs
   logic        rx_reseed_reg, rx_seed, rx_scr;
   logic [31:0] rx_lfsr_reg, rx_mask;
   assign rx_seed = (cell_mode & rx_bound) | rx_reseed_reg;
   assign rx_mask = rx_seed ? BCF_SEED : rx_lfsr_reg;
   // [RULE11] descramble data words only
   assign rx_scr  = ctrl_reg.scramble_enable & ~rx_cmd & ~rx_is_mark;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_lfsr_reg   <= BCF_SEED;
         rx_reseed_reg <= 1'b0;
      end else begin
         rx_lfsr_reg   <= lfsr_step(rx_mask);
         rx_reseed_reg <= rx_cmd | rx_is_mark;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_data               <= '0;
         rx_word_type          <= BCF_TYPE_CMD;
         rx_word_valid         <= 1'b0;
         cell_sync_error_pulse <= 1'b0;
         link_error_pulse      <= 1'b0;
      end else begin
         // [RULE2] overhead bits shown as word type
         // [RULE3] overhead passes unchanged
         rx_word_type          <= rx_ser_word.ovh;
         rx_data <= rx_scr ? rx_ser_word.data ^ rx_mask : rx_ser_word.data;
         // [RULE17] idle words are not valid
         rx_word_valid         <= ~rx_idle;
         cell_sync_error_pulse <= rx_sync_err;
         link_error_pulse      <= rx_bad_pat;
      end
   end

   // ---- AXI4-Lite write channel
   logic        aw_got_reg, w_got_reg;
   logic [3:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic        do_wr, wr_ok;
   assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;
   assign do_wr = aw_got_reg & w_got_reg & ~s_axi_bvalid;
   assign wr_ok = aw_addr_reg == BCF_OFF_CTRL ||
                  aw_addr_reg == BCF_OFF_TIMING ||
                  aw_addr_reg == BCF_OFF_STATUS;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg   <= 1'b0;
         w_got_reg    <= 1'b0;
         aw_addr_reg  <= 4'h0;
         w_data_reg   <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= BCF_RESP_OK;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_got_reg  <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[3:2], 2'h0};
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_got_reg  <= 1'b1;
            w_data_reg <= s_axi_wdata;
         end
         if (do_wr) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? BCF_RESP_OK : BCF_RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control register
   always_ff @(posedge aclk) begin
      if (!aresetn) ctrl_reg <= BCF_CTRL_RST;
      else if (do_wr && aw_addr_reg == BCF_OFF_CTRL)
         ctrl_reg <= bcf_ctrl_type'(w_data_reg[$bits(bcf_ctrl_type)-1:0]);
   end

   // Timing register; with flow ready low a delay command word also sets the receive lag
   always_ff @(posedge aclk) begin
      if (!aresetn) timing_reg <= BCF_TIMING_RST;
      else if (do_wr && aw_addr_reg == BCF_OFF_TIMING)
         timing_reg <= bcf_timing_type'(w_data_reg[$bits(bcf_timing_type)-1:0]);
      // [RULE7] command word changes the lag
      else if (rx_dly_cmd && !ctrl_reg.flow_ready_input)
         timing_reg.rx_delay <= rx_ser_word.data[7:0];
   end

   // Sticky link and cell error flags, a new event beats the clear; config error follows the setup
   logic        clr_link, clr_cell;
   assign clr_link = do_wr && aw_addr_reg == BCF_OFF_STATUS && w_data_reg[0];
   assign clr_cell = do_wr && aw_addr_reg == BCF_OFF_STATUS && w_data_reg[1];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_reg <= '0;
      end else begin
         status_reg.config_err <= config_bad;
         status_reg.link_err   <= link_error_pulse |
                                  (status_reg.link_err & ~clr_link);
         status_reg.cell_err   <= cell_sync_error_pulse |
                                  (status_reg.cell_err & ~clr_cell);
      end
   end

   // Cell sync error count, saturating
   always_ff @(posedge aclk) begin
      if (!aresetn) errcnt_reg <= '0;
      else if (cell_sync_error_pulse && errcnt_reg != '1)
         errcnt_reg <= errcnt_reg + 32'h1;
   end

   // ---- AXI4-Lite read channel
   logic [3:0] ra;
   assign ra = {s_axi_araddr[3:2], 2'h0};
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= BCF_RESP_OK;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= BCF_RESP_OK;
         case (ra)
            BCF_OFF_CTRL:   s_axi_rdata <= 32'(ctrl_reg);
            BCF_OFF_TIMING: s_axi_rdata <= 32'(timing_reg);
            BCF_OFF_STATUS: s_axi_rdata <= 32'(status_reg);
            BCF_OFF_ERRCNT: s_axi_rdata <= errcnt_reg;
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= BCF_RESP_ERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---- Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_late_idle;
      cell_mode && rx_last && rx_idle_op;
   endsequence
   sequence s_err_once;
      cell_sync_error_pulse ##1 (status_reg.cell_err && errcnt_reg != '0);
   endsequence

   chk_tx_type_pass: assert property ( // [RULE1]
      tx_word_valid |=> tx_ser_word.ovh == $past(tx_word_type))
      else $error("transmit overhead differs from word type");
   chk_rx_type_pass: assert property ( // [RULE2]
      1'b1 |=> rx_word_type == $past(rx_ser_word.ovh))
      else $error("receive word type differs from overhead");
   chk_cmd_unscrambled: assert property ( // [RULE11]
      tx_word_valid && tx_word_type == BCF_TYPE_CMD
      |=> tx_ser_word.data == $past(tx_data))
      else $error("command word altered");
   chk_scramble_enable_off_clean: assert property ( // [RULE11]
      tx_word_valid && !ctrl_reg.scramble_enable
      |=> tx_ser_word.data == $past(tx_data))
      else $error("word scrambled with scrambling off");
   chk_cell_seed: assert property ( // [RULE12]
      cell_mode && tx_bound && tx_word_valid && ctrl_reg.scramble_enable &&
      tx_word_type != BCF_TYPE_CMD
      |=> tx_ser_word.data == ($past(tx_data) ^ BCF_SEED))
      else $error("scrambler not restarted on cell");
   chk_last_idle_mark: assert property ( // [RULE15]
      cell_mode && tx_last && !tx_word_valid
      |=> tx_ser_word.ovh == BCF_TYPE_MARK)
      else $error("last slot idle not marked 11");
   chk_idle_rx_invalid: assert property ( // [RULE17]
      rx_idle |=> !rx_word_valid && rx_word_type != 2'h1)
      else $error("idle word shown as valid");
   chk_sync_err_pulse: assert property ( // [RULE18]
      s_late_idle |=> s_err_once)
      else $error("cell sync error not flagged");
   chk_link_pattern: assert property ( // [RULE13]
      rx_bad_pat |=> link_error_pulse ##1 status_reg.link_err)
      else $error("bad idle pattern not reported");
   chk_slot_wrap: assert property ( // [RULE25]
      tx_bound && timing_reg.cell_len > 8'h1 |=> tx_cnt_reg == 8'h1)
      else $error("slot counter not restarted");
endmodule : bcf_framer
`default_nettype wire

/* tb/bcf_far_end.sv */
// Far end model: switch or peer feeding the receive word path
`timescale 1ns/100ps
`default_nettype none
module bcf_far_end
   import bcf_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              send,
   input  wire bcf_ser_word_type  word,
   input  wire logic              cell_run,
   output bcf_ser_word_type       rx_ser_word,
   output logic                   cell_clk_in
);
   // user words or idle fill
   // Idle command words fill every slot with nothing to send
   always_ff @(posedge aclk) begin
      if (!aresetn || !send) begin
         rx_ser_word <= {BCF_TYPE_CMD, BCF_IDLE_WORD};
      end else begin
         rx_ser_word <= word;
      end
   end
   // Cell clock, 160 ns period, held low while stopped
   initial begin
      cell_clk_in = 1'b0;
      #7;
      forever begin
         #80;
         cell_clk_in = cell_run ? ~cell_clk_in : 1'b0;
      end
   end
endmodule : bcf_far_end
`default_nettype wire

/* tb/bcf_framer_tb.sv */
// Self-checking bench for the passthrough cell framer
`timescale 1ns/100ps
`default_nettype none
module bcf_framer_tb
   import bcf_pkg::*;
;
   logic        aclk, aresetn, far_send, cell_run, tcc, rcc;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, tx_word_valid, rx_word_valid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, tx_word_type, rx_word_type, r;
   logic [31:0] s_axi_wdata, s_axi_rdata, tx_data, rx_data, q;
   logic        cell_sync_error_pulse, link_error_pulse, cell_clk_in;
   logic [4:0]  cfg;
   bcf_ser_word_type tx_ser_word, rx_ser_word, far_word;
   int          fails = 0, compares = 0, cyc = 0, n, k, hits, marks, vals;
   int          bnds;
   logic [34:0] rows [5] = '{35'h5_1234_5678, 35'h6_9abc_def0,
      35'h7_0f0f_0f0f, 35'h4_1122_3344, 35'h0_a5c3_3c96};
   logic [12:0] ctab [3] = '{13'h2a5, 13'heac, 13'h093};

   bcf_framer #(.DLY_MAX(16)) DUT (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_data,
      .tx_word_type, .tx_word_valid, .rx_data, .rx_word_type, .rx_word_valid,
      .cell_sync_error_pulse, .link_error_pulse, .tx_ser_word, .rx_ser_word,
      .cell_clk_in, .tx_cell_clock(tcc), .rx_cell_clock(rcc),
      .self_route_enable(cfg[4]), .tx_align_enable(cfg[3]),
      .rx_align_enable(cfg[2]), .word_boundary_master(cfg[1]),
      .tx_clock_from_cmu(cfg[0]));
   bcf_far_end FAR (.aclk, .aresetn, .send(far_send), .word(far_word),
      .cell_run, .rx_ser_word, .cell_clk_in);

   // Clock and hang guard
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         give_verdict();
      end
   end

   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   // One bus transfer; holds each channel until its ready is seen
   task automatic axi(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic [1:0] rs);
      logic ta, tw, tr, done;
      int   c;
      c = 0;
      done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      while (!done && c < 40) begin
         @(negedge aclk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tr = s_axi_arready;
         done = w ? s_axi_bvalid : s_axi_rvalid;
         rd = s_axi_rdata;
         rs = w ? s_axi_bresp : s_axi_rresp;
         @(posedge aclk);
         c++;
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) s_axi_arvalid <= 1'b0;
      end
      {s_axi_bready, s_axi_rready} <= 2'b00;
      @(posedge aclk);
      if (!done) fails++;
   endtask : axi

   task automatic give_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   // Main sequence
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
      {s_axi_arvalid, s_axi_rready, s_axi_wstrb} = 6'h0f;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {tx_data, tx_word_type, tx_word_valid, far_send, cell_run} = '0;
      far_word = '0;
      aresetn = 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      axi(1'b1, 4'h0, 32'h01, q, r);
      for (n = 0; n < 5; n++) begin
         {tx_word_type, tx_data} <= rows[n][33:0];
         far_word <= rows[n][33:0];
         {tx_word_valid, far_send} <= 2'b11;
         @(posedge aclk);
         @(negedge aclk);
         chk(tx_ser_word, rows[n][33:0]);
         @(posedge aclk);
         @(negedge aclk);
         chk({rx_word_valid, rx_word_type, rx_data}, rows[n]);
         @(posedge aclk);
      end
      // Command unscrambled, data after it scrambled, then an idle slot
      axi(1'b1, 4'h0, 32'h05, q, r);
      {tx_word_type, tx_data} <= {2'h0, 32'h11223344};
      @(posedge aclk);
      {tx_word_type, tx_data} <= {2'h1, 32'h12345678};
      @(negedge aclk);
      chk(tx_ser_word, {2'h0, 32'h11223344});
      @(posedge aclk);
      tx_word_valid <= 1'b0;
      @(negedge aclk);
      chk(tx_ser_word, {2'h1, 32'hedcba987});
      @(negedge aclk);
      chk(tx_ser_word, {BCF_TYPE_CMD, BCF_IDLE_WORD});
      // Idle word with a broken pattern
      @(posedge aclk);
      far_word <= {2'h0, 32'ha5000000};
      @(posedge aclk);
      far_send <= 1'b0;
      @(posedge aclk);
      @(negedge aclk);
      chk(link_error_pulse, 1'b1);
      @(posedge aclk);
      axi(1'b0, 4'h8, 32'h0, q, r);
      chk(q[0], 1'b1);
      // Cell mode, marker boundary then cell clock boundary, idles only
      axi(1'b1, 4'h4, 32'h04, q, r);
      cell_run <= 1'b1;
      for (k = 0; k < 2; k++) begin
         axi(1'b1, 4'h0, k ? 32'h07 : 32'h0f, q, r);
         far_send <= 1'b1;
         far_word <= {BCF_TYPE_MARK, BCF_IDLE_WORD};
         @(posedge aclk);
         far_send <= 1'b0;
         {hits, marks, vals, bnds} = '0;
         repeat (40) begin
            @(negedge aclk);
            hits += cell_sync_error_pulse;
            marks += (tx_ser_word === {BCF_TYPE_MARK, BCF_IDLE_WORD});
            vals += (rx_word_valid !== 1'b0);
            bnds += (tcc && rcc);
         end
         chk(hits != 0, 1'b1);
         chk(marks != 0, 1'b1);
         chk(bnds != 0, 1'b1);
         chk(vals == 0, 1'b1);
         @(posedge aclk);
      end
      // Delay command word sets the receive lag
      far_word <= {BCF_TYPE_CMD, BCF_DLY_OP, 24'h00_0003};
      far_send <= 1'b1;
      @(posedge aclk);
      far_send <= 1'b0;
      @(posedge aclk);
      axi(1'b0, 4'h4, 32'h0, q, r);
      chk(q, 32'h0003_0004);
      axi(1'b0, 4'h8, 32'h0, q, r);
      chk(q[1], 1'b1);
      axi(1'b0, 4'hc, 32'h0, q, r);
      chk(q != 0, 1'b1);
      // Static configuration outputs per mode
      for (n = 0; n < 3; n++) begin
         axi(1'b1, 4'h0, {24'h0, ctab[n][12:5]}, q, r);
         chk(cfg, ctab[n][4:0]);
      end
      axi(1'b1, 4'hc, 32'h0, q, r);
      chk(r, BCF_RESP_ERR);
      // Reset in mid-run
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      @(negedge aclk);
      chk({rx_word_valid, tx_ser_word}, {1'b0, BCF_TYPE_CMD, BCF_IDLE_WORD});
      @(posedge aclk);
      aresetn <= 1'b1;
      axi(1'b0, 4'h0, 32'h0, q, r);
      chk(q, {25'h0, BCF_CTRL_RST});
      axi(1'b0, 4'h4, 32'h0, q, r);
      chk(q, {8'h0, BCF_TIMING_RST});
      give_verdict();
   end
endmodule : bcf_framer_tb
`default_nettype wire
